// ===== verification/cspk_host_model.sv
// Two-wire bus host model driving the bus clock and pulling the data line.
module cspk_host_model (
   // Clock and resolved data line.
   input  wire logic clk_i,
   input  wire logic sda_i,
   // Host line drivers.
   output logic      scl_o,
   output logic      sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int hp_n = 10;

   // Bus idle, data released to the pull-up.
   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   // A third of a bit; the design needs eight cycles at least.
   task automatic hp();
      repeat (hp_n) @(negedge clk_i);
   endtask

   // Data moves only with the clock low, so no false start or stop is made.
   task automatic bit_x(input logic b, output logic r);
      sda_low_o = ~b;
      hp();
      scl_o = 1'b1;
      hp();
      r = sda_i;
      scl_o = 1'b0;
      hp();
   endtask

   task automatic byte_x(input logic [7:0] b, input logic a, output logic [7:0] r,
                         output logic ack);
      logic ra;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(b[i], r[i]);
      end
      bit_x(a, ra);
      ack = ~ra;
   endtask

   task automatic start();
      sda_low_o = 1'b0;
      hp();
      scl_o = 1'b1;
      hp();
      sda_low_o = 1'b1;
      hp();
      scl_o = 1'b0;
      hp();
   endtask

   task automatic stop();
      sda_low_o = 1'b1;
      hp();
      scl_o = 1'b1;
      hp();
      sda_low_o = 1'b0;
      hp();
   endtask

   task automatic wr(input logic [6:0] adr, input logic [7:0] ofs, d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      start();
      byte_x({adr, 1'b0}, 1'b1, r, a0);
      byte_x(ofs, 1'b1, r, a1);
      byte_x(d, 1'b1, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask

   // Single byte read, closed with a refusal of further data.
   task automatic rd(input logic [6:0] adr, input logic [7:0] ofs, output logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      start();
      byte_x({adr, 1'b0}, 1'b1, r, a0);
      byte_x(ofs, 1'b1, r, a1);
      start();
      byte_x({adr, 1'b1}, 1'b1, r, a2);
      byte_x(8'hff, 1'b1, d, a3);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule

// ===== verification/cspk_props.sv
// Port-level checks for the peak configuration and result register block.
module cspk_props #(
   parameter int TICK_CYCLES = 250
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Bus pins.
   input  wire logic        scl_i,
   input  wire logic        sda_o,
   input  wire logic        sda_oe_o,
   // Shunt result input.
   input  wire logic [11:0] shunt_voltage_i,
   input  wire logic        shunt_valid_i,
   // Event and range outputs.
   input  wire logic        critical_event_pin_o,
   input  wire logic        limit_event_o,
   input  wire logic [1:0]  shunt_full_scale_sel_o
);
   // Nothing at or below the lowest threshold of any range can count as a spike.
   localparam logic [11:0] LOW_CAP = 12'h100;
   localparam int          MIN_CYC = 1000 * TICK_CYCLES - 2;
   logic [23:0] quiet_q;
   logic [23:0] quiet_d;
   logic [3:0]  vcnt_q;
   logic [3:0]  vcnt_d;
   logic        low_w;
   logic        evt_w;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Cycles since a result that cannot be above threshold, and since any result.
   assign low_w  = shunt_valid_i && (shunt_voltage_i[11] || shunt_voltage_i <= LOW_CAP);
   assign evt_w  = critical_event_pin_o | limit_event_o;
   assign quiet_d = low_w ? 24'h0 : (&quiet_q ? quiet_q : quiet_q + 24'h1);
   assign vcnt_d  = shunt_valid_i ? 4'h0 : (&vcnt_q ? vcnt_q : vcnt_q + 4'h1);

   // Saturating counters, so a long quiet spell never wraps into a false pass.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         quiet_q <= 24'h0;
         vcnt_q  <= 4'h0;
      end
      else
      begin
         quiet_q <= quiet_d;
         vcnt_q  <= vcnt_d;
      end
   end

   sequence s_negative;
      shunt_valid_i && shunt_voltage_i[11];
   endsequence

   sequence s_no_event;
      !critical_event_pin_o && !limit_event_o;
   endsequence

   AST_RST_OUT: assert property (
      $rose(rstn_i) |-> shunt_full_scale_sel_o == 2'h3 && !sda_oe_o && !evt_w)
      else $error("outputs not at rest after reset");
   AST_ONE_ROUTE: assert property (
      !(critical_event_pin_o && limit_event_o))
      else $error("spike sent to both event outputs");
   AST_NEG_CLEARS: assert property (
      s_negative |-> ##4 s_no_event)
      else $error("negative shunt result left an event set");
   AST_MIN_DUR: assert property (
      $rose(evt_w) |-> quiet_q >= MIN_CYC)
      else $error("spike reported before minimum duration");
   AST_FALL_CAUSE: assert property (
      $fell(evt_w) |-> vcnt_q <= 4'h6 || !scl_i)
      else $error("event cleared without new result or write");
   AST_FS_CHANGE: assert property (
      $changed(shunt_full_scale_sel_o) |-> !scl_i)
      else $error("full scale changed outside a write");
   AST_OE_AT_LOW: assert property (
      $changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed while bus clock high");
   AST_OPEN_DRAIN: assert property (
      sda_oe_o |-> sda_o == 1'b0)
      else $error("data line driven high");
endmodule

bind cspk_top cspk_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clk_i                  (clk_i),
   .rstn_i                 (rstn_i),
   .scl_i                  (scl_i),
   .sda_o                  (sda_o),
   .sda_oe_o               (sda_oe_o),
   .shunt_voltage_i        (shunt_voltage_i),
   .shunt_valid_i          (shunt_valid_i),
   .critical_event_pin_o   (critical_event_pin_o),
   .limit_event_o          (limit_event_o),
   .shunt_full_scale_sel_o (shunt_full_scale_sel_o)
);

// ===== verification/testbench.sv
// Self-checking bench for the peak configuration and result registers.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADR  = 7'h4c;
   localparam int         DUR0 = 1000;
   logic        clk, rstn, scl, sda_low, sda_o, sda_oe, crit, lim, svld, vvld;
   logic [11:0] shunt, supply;
   logic [1:0]  fs;
   wire logic   sda;
   int          bad_count = 0;
   int          n_compared = 0;

   // Pull-up on the data line; either party may pull it low.
   assign sda = ~(sda_low | (sda_oe & ~sda_o));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // A one-cycle tick keeps duration code 0 at a thousand cycles.
   cspk_top #(.TICK_CYCLES(1)) uut (
      .clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .threshold_strap_pin_i(4'ha),
      .duration_strap_pin_i(4'h5), .shunt_voltage_i(shunt), .shunt_valid_i(svld),
      .supply_voltage_i(supply), .supply_valid_i(vvld), .critical_event_pin_o(crit),
      .limit_event_o(lim), .shunt_full_scale_sel_o(fs));

   cspk_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   task automatic chk(input string nm, input logic [11:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rreg(input logic [7:0] ofs, output logic [7:0] d);
      logic ok;
      host.rd(ADR, ofs, d, ok);
      chk("read ack", {11'h0, ok}, 12'h001);
   endtask

   task automatic wreg(input logic [7:0] ofs, d);
      logic ok;
      host.wr(ADR, ofs, d, ok);
      chk("write ack", {11'h0, ok}, 12'h001);
   endtask

   task automatic drive(input logic [11:0] sh, sp);
      @(negedge clk);
      shunt  = sh;
      supply = sp;
      svld   = 1'b1;
      vvld   = 1'b1;
      @(negedge clk);
      svld = 1'b0;
      vvld = 1'b0;
   endtask

   task automatic wait_evt(input int lim_n, output int n);
      n = 0;
      while ((crit | lim) !== 1'b1 && n < lim_n)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] res [4] = '{cspk_pkg::OFS_SHUNT_HI, cspk_pkg::OFS_SHUNT_LO,
                              cspk_pkg::OFS_SUPPLY_HI, cspk_pkg::OFS_SUPPLY_LO};
      rreg(cspk_pkg::OFS_PEAK_CFG, d);
      chk("strap cfg", {4'h0, d}, 12'h0a5);
      rreg(cspk_pkg::OFS_VSAMP_CFG, d);
      chk("route cfg", {4'h0, d}, 12'h0c0);
      chk("full scale", {10'h0, fs}, 12'h003);
      for (int i = 0; i < 4; i++)
      begin
         rreg(res[i], d);
         chk("result reset", {4'h0, d}, 12'h000);
      end
      $display("test reset done");
   endtask

   task automatic t_cfg();
      logic [7:0] d;
      logic       ok;
      wreg(cspk_pkg::OFS_PEAK_CFG, 8'h3c);
      wreg(cspk_pkg::OFS_SHUNT_HI, 8'h5a);
      wreg(8'h70, 8'h77);
      wreg(cspk_pkg::OFS_CSAMP_CFG, 8'h01);
      host.wr(7'h4d, cspk_pkg::OFS_PEAK_CFG, 8'h11, ok);
      chk("foreign address ack", {11'h0, ok}, 12'h000);
      rreg(cspk_pkg::OFS_PEAK_CFG, d);
      chk("written cfg", {4'h0, d}, 12'h03c);
      rreg(cspk_pkg::OFS_SHUNT_HI, d);
      chk("read-only result", {4'h0, d}, 12'h000);
      chk("full scale written", {10'h0, fs}, 12'h001);
      rstn = 1'b0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      chk("full scale reset", {10'h0, fs}, 12'h003);
      rreg(cspk_pkg::OFS_PEAK_CFG, d);
      chk("strap cfg again", {4'h0, d}, 12'h0a5);
      $display("test config done");
   endtask

   task automatic t_result();
      logic [11:0] sc [4] = '{12'h7ff, 12'h800, 12'hffe, 12'h001};
      logic [11:0] vc [4] = '{12'h276, 12'h7ff, 12'hfff, 12'h800};
      logic [7:0]  h, l;
      for (int i = 0; i < 4; i++)
      begin
         drive(sc[i], vc[i]);
         rreg(cspk_pkg::OFS_SHUNT_HI, h);
         rreg(cspk_pkg::OFS_SHUNT_LO, l);
         chk("shunt", {h, l[7:4]}, sc[i]);
         chk("shunt low pad", {8'h0, l[3:0]}, 12'h000);
         rreg(cspk_pkg::OFS_SUPPLY_HI, h);
         rreg(cspk_pkg::OFS_SUPPLY_LO, l);
         chk("supply", {1'b0, h, l[7:5]}, vc[i][11] ? 12'h0 : {1'b0, vc[i][10:0]});
         chk("supply low pad", {7'h0, l[4:0]}, 12'h000);
      end
      $display("test result done");
   endtask

   task automatic t_spike();
      int n;
      wreg(cspk_pkg::OFS_PEAK_CFG, 8'h10);
      drive(12'd384, 12'h0);
      wait_evt(1500, n);
      chk("at threshold", {10'h0, lim, crit}, 12'h000);
      drive(12'd385, 12'h0);
      wait_evt(1500, n);
      chk("spike delay", {11'h0, n >= DUR0 - 1 && n <= DUR0 + 4}, 12'h001);
      chk("critical route", {10'h0, lim, crit}, 12'h001);
      drive(12'h0, 12'h0);
      repeat (4) @(negedge clk);
      chk("spike cleared", {10'h0, lim, crit}, 12'h000);
      wreg(cspk_pkg::OFS_VSAMP_CFG, 8'h00);
      drive(12'd385, 12'h0);
      wait_evt(1500, n);
      chk("limit route", {10'h0, lim, crit}, 12'h002);
      drive(12'h0, 12'h0);
      wreg(cspk_pkg::OFS_PEAK_CFG, 8'h11);
      drive(12'd385, 12'h0);
      repeat (2000) @(negedge clk);
      wreg(cspk_pkg::OFS_PEAK_CFG, 8'hf1);
      wait_evt(6000, n);
      chk("raised threshold", {10'h0, lim, crit}, 12'h000);
      drive(12'h0, 12'h0);
      $display("test spike done");
   endtask

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Reset, then the scenarios in order.
   initial
   begin
      rstn   = 1'b0;
      shunt  = 12'h0;
      supply = 12'h0;
      svld   = 1'b0;
      vvld   = 1'b0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      t_reset();
      t_cfg();
      t_result();
      t_spike();
      complete_run();
   end

   // The run needs about 200 us of bus traffic and event waits; well past that means a hang.
   initial
   begin
      #360000;
      bad_count++;
      complete_run();
   end
endmodule

// ===== verilog/cspk_pkg.sv
// Constants shared by the current-sense peak and result register block.
package cspk_pkg;

   // Register offsets on the management bus.
   localparam logic [7:0] OFS_VSAMP_CFG  = 8'h50;
   localparam logic [7:0] OFS_CSAMP_CFG  = 8'h51;
   localparam logic [7:0] OFS_PEAK_CFG   = 8'h52;
   localparam logic [7:0] OFS_SHUNT_HI   = 8'h54;
   localparam logic [7:0] OFS_SHUNT_LO   = 8'h55;
   localparam logic [7:0] OFS_SUPPLY_HI  = 8'h58;
   localparam logic [7:0] OFS_SUPPLY_LO  = 8'h59;

   // Reset values.
   localparam logic [7:0] RST_PEAK_CFG   = 8'h00;
   localparam logic       RST_ROUTE      = 1'b1;
   localparam logic [1:0] RST_FULL_SCALE = 2'h3;
   localparam logic [7:0] RST_RESULT     = 8'h00;

   // Field positions.
   localparam int POS_ROUTE     = 7;
   localparam int POS_VSAMP_ONE = 6;
   localparam int POS_THR_LSB   = 4;

   // Timing: one microsecond tick derived from the 4 ns clock.
   localparam int CLK_PERIOD_NS  = 4;
   localparam int TICK_TIME_NS   = 1000;
   localparam int US_TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

   // Cycles counted after reset release before the strap load is armed.
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Minimum spike durations in microseconds, indexed by duration code.
   localparam logic [22:0] DUR_US [16] = '{
      23'd1000,    23'd5120,    23'd25600,   23'd51200,
      23'd76800,   23'd102400,  23'd128000,  23'd256000,
      23'd384000,  23'd512000,  23'd768000,  23'd1024000,
      23'd1536000, 23'd2048000, 23'd3072000, 23'd4096000
   };

   // Threshold steps: 10 mV base, 5 mV step; full scale is 10 mV shifted by range.
   localparam logic [14:0] THR_UNIT = 15'h0400;
   localparam logic [4:0]  THR_BASE = 5'h02;

   // Bus state machine.
   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_RX,
      BUS_ACK,
      BUS_TX,
      BUS_MACK
   } cspk_bus_t;

endpackage

// ===== verilog/cspk_top.sv
// Peak detector configuration and shunt/supply result registers behind a management bus.

// Functional notes
// - Eight-bit read-write peak config register, reset zero, threshold high nibble, duration low.
// - Peak detector always uses the live config register fields, no hidden copy.
// - Straps load config after power-up; any host write replaces them until reset.
// - Host writes to peak config are accepted at any time, even mid-measurement.
// - Threshold code selects 10 mV plus 5 mV per step, up to 85 mV.
// - Duration codes 0-7 select 1, 5.12, 25.6, 51.2, 76.8, 102.4, 128, 256 ms.
// - Duration codes 8-15 select 384, 512, 768, 1024, 1536, 2048, 3072, 4096 ms.
// - Read-only 12-bit shunt result: top eight in high byte, four in low nibble-high.
// - Shunt result is two's complement; extremes equal programmed full scale, zero is zero.
// - Shunt result is stored raw as a fraction of full scale, no rescaling.
// - Shunt sign bit is zero for forward current, one for reverse current.
// - Read-only unsigned 11-bit supply result, low five bits of low byte read zero.
// - Supply code is plain weighted binary, 12 V down to 0.0117 V per bit.
// - Negative supply measurements are stored as an all-zero result.
// - Two-bit range selects 10, 20, 40 or 80 mV full scale, default 80 mV.
// - Route bit sends spikes to the critical pin when set, else limit pin.
module cspk_top #(
   parameter logic [6:0] SLAVE_ADDR  = 7'h4c,
   parameter int         TICK_CYCLES = cspk_pkg::US_TICK_CYCLES
) (
   // Clock, reset and freeze.
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   // Management bus pins, open drain data.
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Strap pins.
   input  wire logic [3:0]  threshold_strap_pin_i,
   input  wire logic [3:0]  duration_strap_pin_i,
   // Conversion results from the measurement logic.
   input  wire logic [11:0] shunt_voltage_i,
   input  wire logic        shunt_valid_i,
   input  wire logic [11:0] supply_voltage_i,
   input  wire logic        supply_valid_i,
   // Spike events and full-scale selection.
   output logic             critical_event_pin_o,
   output logic             limit_event_o,
   output logic [1:0]       shunt_full_scale_sel_o
);

   // Threshold in shunt codes: (2+k)*1024 shifted right by the range code.
   function automatic logic [14:0] thr_codes(input logic [3:0] k, input logic [1:0] s);
      logic [14:0] base;
      base = 15'({cspk_pkg::THR_BASE + {1'b0, k}}) * cspk_pkg::THR_UNIT;
      return base >> s;
   endfunction

   // Pin synchronisers, three stages; a change counts when stages two and three agree.
   logic [2:0] scl_sy_q;
   logic [2:0] sda_sy_q;
   logic [2:0] thr_sy_q [4];
   logic [2:0] dur_sy_q [4];
   logic       scl_f_q;
   logic       sda_f_q;
   logic [3:0] thr_strap_q;
   logic [3:0] dur_strap_q;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         scl_sy_q <= 3'h7;
         sda_sy_q <= 3'h7;
         scl_f_q  <= 1'b1;
         sda_f_q  <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_sy_q <= {scl_sy_q[1:0], scl_i};
         sda_sy_q <= {sda_sy_q[1:0], sda_i};
         if (scl_sy_q[1] == scl_sy_q[2])
            scl_f_q <= scl_sy_q[2];
         if (sda_sy_q[1] == sda_sy_q[2])
            sda_f_q <= sda_sy_q[2];
      end
   end

   // Strap pins are slow levels; each bit gets its own filtered copy.
   for (genvar b = 0; b < 4; b++)
   begin : g_strap
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
         if (!rstn_i)
         begin
            thr_sy_q[b]    <= 3'h0;
            dur_sy_q[b]    <= 3'h0;
            thr_strap_q[b] <= 1'b0;
            dur_strap_q[b] <= 1'b0;
         end
         else if (ce_i)
         begin
            thr_sy_q[b] <= {thr_sy_q[b][1:0], threshold_strap_pin_i[b]};
            dur_sy_q[b] <= {dur_sy_q[b][1:0], duration_strap_pin_i[b]};
            if (thr_sy_q[b][1] == thr_sy_q[b][2])
               thr_strap_q[b] <= thr_sy_q[b][2];
            if (dur_sy_q[b][1] == dur_sy_q[b][2])
               dur_strap_q[b] <= dur_sy_q[b][2];
         end
      end
   end

   // Bus edge and framing conditions on the filtered levels.
   logic scl_d1_q;
   logic sda_d1_q;
   wire  scl_rise = scl_f_q & ~scl_d1_q;
   wire  scl_fall = ~scl_f_q & scl_d1_q;
   wire  bus_start = scl_f_q & scl_d1_q & sda_d1_q & ~sda_f_q;
   wire  bus_stop  = scl_f_q & scl_d1_q & ~sda_d1_q & sda_f_q;

   // Register state.
   logic [7:0]  peak_cfg_q;
   logic        route_q;
   logic [1:0]  full_scale_q;
   logic [11:0] shunt_q;
   logic [10:0] supply_q;
   logic        host_wrote_q;
   logic        strap_done_q;
   logic [1:0]  settle_q;
   logic        strap_arm_q;

   // Bus engine state.
   cspk_pkg::cspk_bus_t st_q;
   logic [3:0]  bit_cnt_q;
   logic [1:0]  byte_idx_q;
   logic [7:0]  shreg_q;
   logic [7:0]  ptr_q;
   logic        rw_q;
   logic        mack_q;
   logic        sda_oe_q;

   // Config fields used live by the detector.
   wire [3:0] thr_code = peak_cfg_q[7:cspk_pkg::POS_THR_LSB];
   wire [3:0] dur_code = peak_cfg_q[cspk_pkg::POS_THR_LSB-1:0];

   // Read data decode; reserved and unmapped locations read zero.
   logic [7:0] rdata;
   always_comb
   begin
      unique case (ptr_q)
         cspk_pkg::OFS_VSAMP_CFG: rdata = {route_q, 1'b1, 6'h00};
         cspk_pkg::OFS_CSAMP_CFG: rdata = {6'h00, full_scale_q};
         cspk_pkg::OFS_PEAK_CFG:  rdata = peak_cfg_q;
         cspk_pkg::OFS_SHUNT_HI:  rdata = shunt_q[11:4];
         cspk_pkg::OFS_SHUNT_LO:  rdata = {shunt_q[3:0], 4'h0};
         cspk_pkg::OFS_SUPPLY_HI: rdata = supply_q[10:3];
         cspk_pkg::OFS_SUPPLY_LO: rdata = {supply_q[2:0], 5'h00};
         default:                 rdata = 8'h00;
      endcase
   end

   // A completed data byte in a write transfer lands in the register at the pointer.
   wire byte_done = (st_q == cspk_pkg::BUS_RX) & scl_fall & (bit_cnt_q == 4'h8);
   wire addr_hit  = shreg_q[7:1] == SLAVE_ADDR;
   wire wr_strobe = byte_done & (byte_idx_q == 2'h2) & ~rw_q;
   wire wr_peak   = wr_strobe & (ptr_q == cspk_pkg::OFS_PEAK_CFG);

   // Bus engine: start and stop override everything, so a broken frame always recovers.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q       <= cspk_pkg::BUS_IDLE;
         scl_d1_q   <= 1'b1;
         sda_d1_q   <= 1'b1;
         bit_cnt_q  <= 4'h0;
         byte_idx_q <= 2'h0;
         shreg_q    <= 8'h00;
         ptr_q      <= 8'h00;
         rw_q       <= 1'b0;
         mack_q     <= 1'b0;
         sda_oe_q   <= 1'b0;
      end
      else if (ce_i)
      begin
         scl_d1_q <= scl_f_q;
         sda_d1_q <= sda_f_q;
         if (bus_start)
         begin
            st_q       <= cspk_pkg::BUS_RX;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'h0;
            sda_oe_q   <= 1'b0;
         end
         else if (bus_stop)
         begin
            st_q     <= cspk_pkg::BUS_IDLE;
            sda_oe_q <= 1'b0;
         end
         else
         begin
            unique case (st_q)
               cspk_pkg::BUS_IDLE:
                  sda_oe_q <= 1'b0;
               cspk_pkg::BUS_RX:
               begin
                  if (scl_rise)
                  begin
                     shreg_q   <= {shreg_q[6:0], sda_f_q};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
                  else if (byte_done)
                  begin
                     if (byte_idx_q == 2'h0 && !addr_hit)
                        st_q <= cspk_pkg::BUS_IDLE;
                     else
                     begin
                        if (byte_idx_q == 2'h0)
                           rw_q <= shreg_q[0];
                        if (byte_idx_q == 2'h1)
                           ptr_q <= shreg_q;
                        sda_oe_q <= 1'b1;
                        st_q     <= cspk_pkg::BUS_ACK;
                     end
                  end
               end
               cspk_pkg::BUS_ACK:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_q <= 4'h0;
                     if (byte_idx_q != 2'h2)
                        byte_idx_q <= byte_idx_q + 2'h1;
                     if (rw_q)
                     begin
                        shreg_q  <= rdata;
                        sda_oe_q <= ~rdata[7];
                        st_q     <= cspk_pkg::BUS_TX;
                     end
                     else
                     begin
                        sda_oe_q <= 1'b0;
                        st_q     <= cspk_pkg::BUS_RX;
                     end
                  end
               end
               cspk_pkg::BUS_TX:
               begin
                  if (scl_rise)
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  else if (scl_fall)
                  begin
                     if (bit_cnt_q == 4'h8)
                     begin
                        sda_oe_q <= 1'b0;
                        st_q     <= cspk_pkg::BUS_MACK;
                     end
                     else
                     begin
                        shreg_q  <= {shreg_q[6:0], 1'b0};
                        sda_oe_q <= ~shreg_q[6];
                     end
                  end
               end
               cspk_pkg::BUS_MACK:
               begin
                  if (scl_rise)
                     mack_q <= ~sda_f_q;
                  else if (scl_fall)
                  begin
                     bit_cnt_q <= 4'h0;
                     if (mack_q)
                     begin
                        shreg_q  <= rdata;
                        sda_oe_q <= ~rdata[7];
                        st_q     <= cspk_pkg::BUS_TX;
                     end
                     else
                        st_q <= cspk_pkg::BUS_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Configuration registers; strap load waits for settled straps after reset release.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         peak_cfg_q   <= cspk_pkg::RST_PEAK_CFG;
         route_q      <= cspk_pkg::RST_ROUTE;
         full_scale_q <= cspk_pkg::RST_FULL_SCALE;
         host_wrote_q <= 1'b0;
         strap_done_q <= 1'b0;
         settle_q     <= 2'h0;
         strap_arm_q  <= 1'b0;
      end
      else if (ce_i)
      begin
         if (settle_q != cspk_pkg::STRAP_SETTLE)
            settle_q <= settle_q + 2'h1;
         // One more cycle, so the filtered strap copy has taken the pin level.
         strap_arm_q <= (settle_q == cspk_pkg::STRAP_SETTLE);
         if (wr_peak)
         begin
            peak_cfg_q   <= shreg_q;
            host_wrote_q <= 1'b1;
         end
         else if (!strap_done_q && !host_wrote_q && strap_arm_q)
         begin
            peak_cfg_q   <= {thr_strap_q, dur_strap_q};
            strap_done_q <= 1'b1;
         end
         if (wr_strobe && ptr_q == cspk_pkg::OFS_VSAMP_CFG)
            route_q <= shreg_q[cspk_pkg::POS_ROUTE];
         if (wr_strobe && ptr_q == cspk_pkg::OFS_CSAMP_CFG)
            full_scale_q <= shreg_q[1:0];
      end
   end

   // Result capture: shunt kept raw, supply clamped at zero when the sign is set.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         shunt_q  <= {cspk_pkg::RST_RESULT, cspk_pkg::RST_RESULT[3:0]};
         supply_q <= {cspk_pkg::RST_RESULT, cspk_pkg::RST_RESULT[2:0]};
      end
      else if (ce_i)
      begin
         if (shunt_valid_i)
            shunt_q <= shunt_voltage_i;
         if (supply_valid_i)
            supply_q <= supply_voltage_i[11] ? 11'h000 : supply_voltage_i[10:0];
      end
   end

   // Peak detector: a microsecond tick drives a duration counter that resets
   // whenever the shunt dips to or below the threshold, so only continuous
   // excursions count. Thresholds beyond full scale can never be reached.
   wire [14:0] thr_now = thr_codes(thr_code, full_scale_q);
   wire        above   = ~shunt_q[11] & ({4'h0, shunt_q[10:0]} > thr_now);
   wire [22:0] dur_now = cspk_pkg::DUR_US[dur_code];

   logic [31:0] tick_cnt_q;
   logic [22:0] us_cnt_q;
   logic        spike_q;
   wire         tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tick_cnt_q <= 32'h0;
         us_cnt_q   <= 23'h0;
         spike_q    <= 1'b0;
      end
      else if (ce_i)
      begin
         tick_cnt_q <= (tick || !above) ? 32'h0 : tick_cnt_q + 32'h1;
         if (!above)
         begin
            us_cnt_q <= 23'h0;
            spike_q  <= 1'b0;
         end
         else if (us_cnt_q >= dur_now)
            spike_q <= 1'b1;
         else if (tick)
            us_cnt_q <= us_cnt_q + 23'h1;
      end
   end

   // Output pins, all registered.
   logic crit_q;
   logic limit_q;
   logic sda_out_q;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         crit_q    <= 1'b0;
         limit_q   <= 1'b0;
         sda_out_q <= 1'b0;
      end
      else if (ce_i)
      begin
         crit_q    <= spike_q & route_q;
         limit_q   <= spike_q & ~route_q;
         sda_out_q <= 1'b0;
      end
   end

   assign sda_o                  = sda_out_q;
   assign sda_oe_o               = sda_oe_q;
   assign critical_event_pin_o   = crit_q;
   assign limit_event_o          = limit_q;
   assign shunt_full_scale_sel_o = full_scale_q;

endmodule
